// ==== hck_cmd_handler.sv ====
// live display, key report, keypad poll, fan fail-safe and tach glitch command handler
//
// How it works
// R1: slot setup carries seven bytes, or two
// R2: eight slots, each independently on or off
// R3: item type 0 none, 1 fan, 2 temperature
// R4: index 0-3 fans, 0-31 attached temperatures
// R5: digits 4/5 for fans, 3/5 temperatures
// R6: column limited by digit count, row 0-1
// R7: accept any slot wholly inside the display
// R8: last byte pulses per rev or units
// R9: temperature crc error shows error text
// R10: too slow tach shows slow text
// R11: shown fan forced full 1/8 per 1/2 s
// R12: commands 0x15-0x1A acked with type or 0x40, store-boot 0x04 not acked
// R13: raw byte passed straight to lcd controller
// R14: per key press/release report masks, default all
// R15: poll returns held, pressed, released masks
// R16: poll ignores the report masks
// R17: host should zero both masks when polling
// R18: fail-safe fans forced full on timeout
// R19: fan power is pwm near 18 Hz
// R20: tach ignored for glitch delay after turn-on
// R21: glitch command four bytes, default one count
// R22: slots, masks, delays saved as boot state
// R23: per-fan timeout restarted by power write
// R24: poll accumulators cleared when poll answers
`timescale 1ns/1ps
module hck_cmd_handler
  import hck_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYC
) (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RSTN,
  input  wire logic        I_CMD_VALID,
  input  wire logic [7:0]  I_CMD_TYPE,
  input  wire logic [3:0]  I_CMD_LEN,
  input  wire logic [55:0] I_CMD_DATA,
  input  wire logic        I_REBOOT,
  input  wire logic [5:0]  I_KEYS,
  input  wire logic [31:0] I_TEMP_PRESENT,
  input  wire logic [31:0] I_TEMP_CRC_ERR,
  input  wire logic [3:0]  I_FAN_SLOW,
  input  wire logic [31:0] I_FAN_PWR,
  input  wire logic [3:0]  I_FAN_PWR_WR,
  input  wire logic [2:0]  I_SLOT_SEL,
  output logic             O_ACK_VALID,
  output logic [7:0]       O_ACK_TYPE,
  output logic [3:0]       O_ACK_LEN,
  output logic [23:0]      O_ACK_DATA,
  output logic             O_LCD_WR,
  output logic [7:0]       O_LCD_BYTE,
  output logic             O_KEY_RPT_VALID,
  output logic [5:0]       O_KEY_PRESS,
  output logic [5:0]       O_KEY_RELEASE,
  output logic [15:0]      O_SLOT_MODE,
  output logic [7:0]       O_SLOT_WIDE,
  output logic [31:0]      O_SLOT_INFO,
  output logic [3:0]       O_FAN_PWM,
  output logic [3:0]       O_TACH_EN,
  output logic [3:0]       O_FAILSAFE_HIT
);
  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  wire         cmd_slot   = I_CMD_VALID && (I_CMD_TYPE == CMD_LIVE_SLOT);
  wire         cmd_lcd    = I_CMD_VALID && (I_CMD_TYPE == CMD_LCD_RAW);
  wire         cmd_kmask  = I_CMD_VALID && (I_CMD_TYPE == CMD_KEY_MASK)
                            && (I_CMD_LEN == LEN_KEY_MASK);
  wire         cmd_poll   = I_CMD_VALID && (I_CMD_TYPE == CMD_KEY_POLL);
  wire         cmd_fsafe  = I_CMD_VALID && (I_CMD_TYPE == CMD_FAILSAFE);
  wire         cmd_glitch = I_CMD_VALID && (I_CMD_TYPE == CMD_GLITCH)
                            && (I_CMD_LEN == LEN_GLITCH);
  wire         cmd_store  = I_CMD_VALID && (I_CMD_TYPE == CMD_STORE_BOOT);
  wire         cmd_ours   = I_CMD_VALID && (I_CMD_TYPE >= CMD_LIVE_SLOT)
                            && (I_CMD_TYPE <= CMD_GLITCH);
  wire [7:0]   d0 = I_CMD_DATA[7:0];
  wire [7:0]   d1 = I_CMD_DATA[15:8];
  wire [7:0]   d2 = I_CMD_DATA[23:16];
  wire [7:0]   d3 = I_CMD_DATA[31:24];
  wire [7:0]   d4 = I_CMD_DATA[39:32];
  wire [7:0]   d5 = I_CMD_DATA[47:40];
  wire [7:0]   d6 = I_CMD_DATA[55:48];
  wire [2:0]   slot_sel = d0[2:0];

  // ---------------------------------------------------------------
  // slot parameter check
  // ---------------------------------------------------------------
  wire fan_ok  = (d2 <= FAN_IDX_MAX)                                           // [R4]
                 && (((d3 == DIG_4) && (d4 <= COL_MAX_4))
                  || ((d3 == DIG_5) && (d4 <= COL_MAX_5)))                     // [R5] [R6]
                 && (d6 >= PPR_MIN) && (d6 <= PPR_MAX);                        // [R8]
  wire tmp_ok  = (d2 <= TMP_IDX_MAX) && I_TEMP_PRESENT[d2[4:0]]                // [R4]
                 && (((d3 == DIG_3) && (d4 <= COL_MAX_3))
                  || ((d3 == DIG_5) && (d4 <= COL_MAX_5)))                     // [R5] [R6]
                 && (d6 <= UNITS_MAX);                                         // [R8]
  wire on_ok   = (I_CMD_LEN == LEN_SLOT_ON) && (d5 <= ROW_MAX)                 // [R1] [R6]
                 && (((d1 == {6'h00, ITEM_FAN}) && fan_ok)
                  || ((d1 == {6'h00, ITEM_TEMP}) && tmp_ok));                  // [R3]
  wire off_ok  = (I_CMD_LEN == LEN_SLOT_OFF) && (d1 == {6'h00, ITEM_NONE});    // [R1] [R3]
  // any in-range position is taken, overlaps included
  wire slot_wr = cmd_slot && (d0 < 8'(NUM_SLOTS)) && (on_ok || off_ok);        // [R7]

  // ---------------------------------------------------------------
  // slot storage, live copy and boot copy
  // ---------------------------------------------------------------
  logic [1:0] s_type_ff [NUM_SLOTS];
  logic [4:0] s_idx_ff  [NUM_SLOTS];
  logic       s_wide_ff [NUM_SLOTS];
  logic [3:0] s_col_ff  [NUM_SLOTS];
  logic       s_row_ff  [NUM_SLOTS];
  logic [5:0] s_aux_ff  [NUM_SLOTS];
  logic [1:0] b_type_ff [NUM_SLOTS];
  logic [4:0] b_idx_ff  [NUM_SLOTS];
  logic       b_wide_ff [NUM_SLOTS];
  logic [3:0] b_col_ff  [NUM_SLOTS];
  logic       b_row_ff  [NUM_SLOTS];
  logic [5:0] b_aux_ff  [NUM_SLOTS];
  logic [1:0] mode_ff   [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] shows_fan [NUM_FANS];

  genvar s;
  generate
    for (s = 0; s < NUM_SLOTS; s++) begin : g_slot
      wire        hit      = slot_wr && (slot_sel == 3'(s));
      wire        is_fan   = (s_type_ff[s] == ITEM_FAN);
      wire        is_tmp   = (s_type_ff[s] == ITEM_TEMP);
      wire [1:0]  nxt_mode = is_fan ? (I_FAN_SLOW[s_idx_ff[s][1:0]] ? SHOW_SLOW : SHOW_VALUE)
                           : is_tmp ? (I_TEMP_CRC_ERR[s_idx_ff[s]] ? SHOW_ERROR : SHOW_VALUE)
                           : SHOW_OFF;                                         // [R9] [R10]
      always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          s_type_ff[s] <= ITEM_NONE;
          s_idx_ff[s]  <= 5'h00;
          s_wide_ff[s] <= 1'b0;
          s_col_ff[s]  <= 4'h0;
          s_row_ff[s]  <= 1'b0;
          s_aux_ff[s]  <= 6'h00;
          mode_ff[s]   <= SHOW_OFF;
        end else if (I_REBOOT) begin                                           // [R22]
          s_type_ff[s] <= b_type_ff[s];
          s_idx_ff[s]  <= b_idx_ff[s];
          s_wide_ff[s] <= b_wide_ff[s];
          s_col_ff[s]  <= b_col_ff[s];
          s_row_ff[s]  <= b_row_ff[s];
          s_aux_ff[s]  <= b_aux_ff[s];
          mode_ff[s]   <= SHOW_OFF;
        end else begin
          mode_ff[s] <= nxt_mode;
          if (hit) begin                                                       // [R2]
            s_type_ff[s] <= d1[1:0];
            s_idx_ff[s]  <= d2[4:0];
            s_wide_ff[s] <= (d3 == DIG_5);
            s_col_ff[s]  <= d4[3:0];
            s_row_ff[s]  <= d5[0];
            s_aux_ff[s]  <= d6[5:0];
          end
        end
      end
      // boot copy: held across soft reboots, only a hard reset clears it
      always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          b_type_ff[s] <= ITEM_NONE;
          b_idx_ff[s]  <= 5'h00;
          b_wide_ff[s] <= 1'b0;
          b_col_ff[s]  <= 4'h0;
          b_row_ff[s]  <= 1'b0;
          b_aux_ff[s]  <= 6'h00;
        end else if (cmd_store) begin                                          // [R22]
          b_type_ff[s] <= s_type_ff[s];
          b_idx_ff[s]  <= s_idx_ff[s];
          b_wide_ff[s] <= s_wide_ff[s];
          b_col_ff[s]  <= s_col_ff[s];
          b_row_ff[s]  <= s_row_ff[s];
          b_aux_ff[s]  <= s_aux_ff[s];
        end
      end
      for (genvar f = 0; f < NUM_FANS; f++) begin : g_map
        assign shows_fan[f][s] = is_fan && (s_idx_ff[s][1:0] == 2'(f));
      end
      assign O_SLOT_MODE[2*s +: 2] = mode_ff[s];
      assign O_SLOT_WIDE[s]        = s_wide_ff[s];
    end
  endgenerate

  // ---------------------------------------------------------------
  // keypad edges, masks and poll accumulators
  // ---------------------------------------------------------------
  logic [5:0] keys_ff, press_mask_ff, rel_mask_ff, b_press_ff, b_rel_ff;
  logic [5:0] since_press_ff, since_rel_ff;
  wire  [5:0] key_dn = I_KEYS & ~keys_ff;
  wire  [5:0] key_up = ~I_KEYS & keys_ff;
  wire  [5:0] acc_press = since_press_ff | key_dn;
  wire  [5:0] acc_rel   = since_rel_ff | key_up;
  wire  [5:0] rpt_press = key_dn & press_mask_ff;                              // [R14]
  wire  [5:0] rpt_rel   = key_up & rel_mask_ff;                                // [R14]

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      keys_ff        <= 6'h00;
      since_press_ff <= 6'h00;
      since_rel_ff   <= 6'h00;
    end else begin
      keys_ff        <= I_KEYS;
      // edges of the poll cycle go into that answer, so clearing loses none
      since_press_ff <= cmd_poll ? 6'h00 : acc_press;                          // [R24]
      since_rel_ff   <= cmd_poll ? 6'h00 : acc_rel;                            // [R24]
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      press_mask_ff <= KEYS_ALL;
      rel_mask_ff   <= KEYS_ALL;
      b_press_ff    <= KEYS_ALL;
      b_rel_ff      <= KEYS_ALL;
    end else begin
      if (I_REBOOT) begin                                                      // [R22]
        press_mask_ff <= b_press_ff;
        rel_mask_ff   <= b_rel_ff;
      end else if (cmd_kmask) begin                                            // [R14]
        press_mask_ff <= d0[5:0];
        rel_mask_ff   <= d1[5:0];
      end
      if (cmd_store) begin
        b_press_ff <= press_mask_ff;
        b_rel_ff   <= rel_mask_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // pwm time base: step of one hundredth period, half-second phase
  // ---------------------------------------------------------------
  logic [31:0] div_ff;
  logic [6:0]  pwm_ff;
  logic [15:0] phase_ff;
  wire         step = (div_ff == 32'(STEP_CYCLES - 1));
  wire         boost_win = (phase_ff < 16'(EIGHTH_STEPS));                     // [R11]

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      div_ff   <= 32'h0000_0000;
      pwm_ff   <= 7'h00;
      phase_ff <= 16'h0000;
    end else begin
      div_ff <= step ? 32'h0000_0000 : div_ff + 32'h0000_0001;
      if (step) begin
        pwm_ff   <= (pwm_ff == PWM_STEPS - 7'h01) ? 7'h00 : pwm_ff + 7'h01;  // [R19]
        phase_ff <= (phase_ff == 16'(HALF_STEPS - 1)) ? 16'h0000 : phase_ff + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // per-fan fail-safe, pwm output and glitch blanking
  // ---------------------------------------------------------------
  logic [3:0]  fs_mask_ff;
  logic [15:0] fs_limit_ff;
  logic [7:0]  dly_ff   [NUM_FANS];
  logic [7:0]  b_dly_ff [NUM_FANS];

  genvar f;
  generate
    for (f = 0; f < NUM_FANS; f++) begin : g_fan
      logic [15:0] fs_cnt_ff;
      logic [7:0]  blank_ff;
      wire  [7:0]  pwr      = I_FAN_PWR[8*f +: 8];
      wire         expired  = fs_mask_ff[f] && (fs_cnt_ff >= fs_limit_ff);
      wire         shown    = |shows_fan[f];
      wire         forced   = O_FAILSAFE_HIT[f] || (shown && boost_win);      // [R11] [R18]
      wire         nxt_on   = forced || (pwr >= PWR_FULL) || ({1'b0, pwm_ff} < pwr);
      wire         turn_on  = nxt_on && !O_FAN_PWM[f];
      always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          fs_cnt_ff         <= 16'h0000;
          O_FAILSAFE_HIT[f] <= 1'b0;
          O_FAN_PWM[f]      <= 1'b0;
          O_TACH_EN[f]      <= 1'b0;
          blank_ff          <= 8'h00;
        end else begin
          if (I_FAN_PWR_WR[f] || (cmd_fsafe && d0[f])) begin                   // [R23]
            fs_cnt_ff         <= 16'h0000;
            O_FAILSAFE_HIT[f] <= 1'b0;
          end else begin
            if (step && !expired) fs_cnt_ff <= fs_cnt_ff + 16'h0001;
            if (expired) O_FAILSAFE_HIT[f] <= 1'b1;                            // [R18] [R23]
          end
          O_FAN_PWM[f] <= nxt_on;
          if (turn_on) blank_ff <= dly_ff[f];                                  // [R20]
          else if (step && (blank_ff != 8'h00)) blank_ff <= blank_ff - 8'h01;
          O_TACH_EN[f] <= O_FAN_PWM[f] && !turn_on && (blank_ff == 8'h00);     // [R20]
        end
      end
      always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          dly_ff[f]   <= GLITCH_DFLT;                                          // [R21]
          b_dly_ff[f] <= GLITCH_DFLT;
        end else begin
          if (I_REBOOT) dly_ff[f] <= b_dly_ff[f];                              // [R22]
          else if (cmd_glitch) dly_ff[f] <= I_CMD_DATA[8*f +: 8];              // [R21]
          if (cmd_store) b_dly_ff[f] <= dly_ff[f];
        end
      end
    end
  endgenerate

  // timeout byte counts eighth seconds of pwm steps
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      fs_mask_ff  <= 4'h0;
      fs_limit_ff <= 16'h0000;
    end else if (cmd_fsafe) begin
      fs_mask_ff  <= d0[3:0];
      fs_limit_ff <= 16'(d1 * 16'(EIGHTH_STEPS));
    end
  end

  // ---------------------------------------------------------------
  // acknowledge, lcd pass-through, key reports, slot readback
  // ---------------------------------------------------------------
  wire [31:0] sel_info = {8'h00, 2'h0, s_aux_ff[I_SLOT_SEL], s_row_ff[I_SLOT_SEL],
                          s_wide_ff[I_SLOT_SEL], s_col_ff[I_SLOT_SEL],
                          s_idx_ff[I_SLOT_SEL], 3'h0, s_type_ff[I_SLOT_SEL]};

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_ACK_VALID     <= 1'b0;
      O_ACK_TYPE      <= 8'h00;
      O_ACK_LEN       <= LEN_EMPTY;
      O_ACK_DATA      <= 24'h000000;
      O_LCD_WR        <= 1'b0;
      O_LCD_BYTE      <= 8'h00;
      O_KEY_RPT_VALID <= 1'b0;
      O_KEY_PRESS     <= 6'h00;
      O_KEY_RELEASE   <= 6'h00;
      O_SLOT_INFO     <= 32'h0000_0000;
    end else begin
      O_ACK_VALID <= cmd_ours;                                                 // [R12]
      if (cmd_ours) begin
        O_ACK_TYPE <= I_CMD_TYPE | ACK_FLAG;                                   // [R12]
        O_ACK_LEN  <= cmd_poll ? LEN_POLL_ACK : LEN_EMPTY;
        // poll sees raw key state, never the report masks
        O_ACK_DATA <= cmd_poll ? {2'h0, acc_rel, 2'h0, acc_press, 2'h0, I_KEYS}
                               : 24'h000000;                                   // [R15] [R16]
      end
      O_LCD_WR        <= cmd_lcd;                                              // [R13]
      if (cmd_lcd) O_LCD_BYTE <= d0;                                           // [R13]
      O_KEY_RPT_VALID <= |{rpt_press, rpt_rel};
      O_KEY_PRESS     <= rpt_press;
      O_KEY_RELEASE   <= rpt_rel;
      O_SLOT_INFO     <= sel_info;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);

  a_ack_type_or: assert property (cmd_ours |=> O_ACK_VALID                    // [R12]
    && (O_ACK_TYPE == ($past(I_CMD_TYPE) | ACK_FLAG)))
    else $error("ack type is not command type with 0x40");
  a_bad_len_kept: assert property (cmd_slot && !on_ok && !off_ok && !I_REBOOT  // [R1]
    |=> s_type_ff[$past(slot_sel)] == $past(s_type_ff[slot_sel]))
    else $error("slot changed by a malformed setup");
  a_slot_off_write: assert property (slot_wr && off_ok && !I_REBOOT            // [R3]
    |=> (s_type_ff[$past(slot_sel)] == ITEM_NONE))
    else $error("two byte setup did not switch slot off");
  a_poll_answer: assert property (cmd_poll |=> O_ACK_LEN == LEN_POLL_ACK       // [R15]
    && O_ACK_DATA[5:0] == $past(I_KEYS))
    else $error("poll answer lacks held keys");
  a_poll_clears: assert property (cmd_poll |=> since_press_ff == 6'h00         // [R24]
    && since_rel_ff == 6'h00)
    else $error("poll accumulators not cleared");
  a_poll_unmasked: assert property (cmd_poll && key_dn != 6'h00                // [R16]
    |=> (O_ACK_DATA[13:8] & $past(key_dn)) == $past(key_dn))
    else $error("poll hid a pressed key");
  a_rpt_masked: assert property (O_KEY_RPT_VALID                               // [R14]
    |-> (O_KEY_PRESS & ~$past(press_mask_ff)) == 6'h00)
    else $error("masked key press reported");
  a_failsafe_full: assert property (O_FAILSAFE_HIT[0] |=> O_FAN_PWM[0])        // [R18]
    else $error("expired fan not at full power");
  a_pwm_wrap: assert property (step && pwm_ff == PWM_STEPS - 7'h01             // [R19]
    |=> pwm_ff == 7'h00)
    else $error("pwm period is not one hundred steps");
  a_glitch_blank: assert property ($rose(O_FAN_PWM[1]) && dly_ff[1] != 8'h00   // [R20]
    |-> ##1 !O_TACH_EN[1] [*2])
    else $error("tach enabled inside glitch delay");
  a_lcd_pass: assert property (cmd_lcd |=> O_LCD_WR && O_LCD_BYTE == $past(d0)) // [R13]
    else $error("raw lcd byte not passed through");

  c_slot_fan: cover property (slot_wr && on_ok && d1 == {6'h00, ITEM_FAN});
  c_poll_edge: cover property (cmd_poll && key_dn != 6'h00);
  c_failsafe: cover property ($rose(O_FAILSAFE_HIT[0]));
  c_boost: cover property (|shows_fan[1] && boost_win && O_FAN_PWM[1]);
endmodule

// ==== hck_host.sv ====
// host model: issues command packets into the handler
`timescale 1ns/1ps
module hck_host (
  input  wire logic        i_clk,
  output logic             o_valid,
  output logic [7:0]       o_type,
  output logic [3:0]       o_len,
  output logic [55:0]      o_data
);
  initial begin
    o_valid = 1'b0;
    o_type  = 8'h00;
    o_len   = 4'h0;
    o_data  = 56'h0;
  end
  // one-cycle request; caller picks lengths that fit the type
  task automatic send(input logic [7:0] t, input logic [3:0] l, input logic [55:0] d);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_type  <= t;
    o_len   <= l;
    o_data  <= d;
    @(posedge i_clk);
    o_valid <= 1'b0;
    // released type and data turn to junk so stale values cannot pass; length is kept
    o_type  <= ~t;
    o_data  <= ~d;
  endtask
endmodule

// ==== hck_pkg.sv ====
// constants for the host command handler of the live display, keypad and fan logic
package hck_pkg;
  // ---------------------------------------------------------------
  // command and acknowledge codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_STORE_BOOT = 8'h04;
  localparam logic [7:0] CMD_LIVE_SLOT  = 8'h15;
  localparam logic [7:0] CMD_LCD_RAW    = 8'h16;
  localparam logic [7:0] CMD_KEY_MASK   = 8'h17;
  localparam logic [7:0] CMD_KEY_POLL   = 8'h18;
  localparam logic [7:0] CMD_FAILSAFE   = 8'h19;
  localparam logic [7:0] CMD_GLITCH     = 8'h1A;
  localparam logic [7:0] ACK_FLAG       = 8'h40;
  localparam logic [3:0] LEN_SLOT_ON    = 4'h7;
  localparam logic [3:0] LEN_SLOT_OFF   = 4'h2;
  localparam logic [3:0] LEN_KEY_MASK   = 4'h2;
  localparam logic [3:0] LEN_POLL_ACK   = 4'h3;
  localparam logic [3:0] LEN_GLITCH     = 4'h4;
  localparam logic [3:0] LEN_EMPTY      = 4'h0;
  // ---------------------------------------------------------------
  // slot fields
  // ---------------------------------------------------------------
  localparam int         NUM_SLOTS   = 8;
  localparam int         NUM_FANS    = 4;
  localparam logic [1:0] ITEM_NONE   = 2'h0;
  localparam logic [1:0] ITEM_FAN    = 2'h1;
  localparam logic [1:0] ITEM_TEMP   = 2'h2;
  localparam logic [7:0] FAN_IDX_MAX = 8'h03;
  localparam logic [7:0] TMP_IDX_MAX = 8'h1F;
  localparam logic [7:0] DIG_3       = 8'h03;
  localparam logic [7:0] DIG_4       = 8'h04;
  localparam logic [7:0] DIG_5       = 8'h05;
  localparam logic [7:0] COL_MAX_3   = 8'h0D;
  localparam logic [7:0] COL_MAX_4   = 8'h0C;
  localparam logic [7:0] COL_MAX_5   = 8'h0B;
  localparam logic [7:0] ROW_MAX     = 8'h01;
  localparam logic [7:0] PPR_MIN     = 8'h01;
  localparam logic [7:0] PPR_MAX     = 8'h20;
  localparam logic [7:0] UNITS_MAX   = 8'h01;
  // slot display modes
  localparam logic [1:0] SHOW_OFF    = 2'h0;
  localparam logic [1:0] SHOW_VALUE  = 2'h1;
  localparam logic [1:0] SHOW_ERROR  = 2'h2;
  localparam logic [1:0] SHOW_SLOW   = 2'h3;
  // ---------------------------------------------------------------
  // keys and fan defaults
  // ---------------------------------------------------------------
  localparam logic [5:0] KEYS_ALL     = 6'h3F;
  localparam logic [7:0] GLITCH_DFLT  = 8'h01;
  localparam logic [7:0] PWR_FULL     = 8'h64;
  localparam logic [6:0] PWM_STEPS    = 7'h64;
  // ---------------------------------------------------------------
  // timing: one pwm step is the glitch count unit
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 10000;
  localparam int STEP_PS       = 552500000;
  localparam int STEP_CYC      = STEP_PS / CLK_PERIOD_PS;
  localparam int HALF_S_US     = 500000;
  localparam int EIGHTH_S_US   = 125000;
  localparam int STEP_NS       = STEP_PS / 1000;
  localparam int HALF_STEPS    = (HALF_S_US * 1000) / STEP_NS;
  localparam int EIGHTH_STEPS  = (EIGHTH_S_US * 1000) / STEP_NS;
endpackage

// ==== tb_top.sv ====
// self-checking bench for the live display, keypad and fan command handler
`timescale 1ns/1ps
module tb_top
  import hck_pkg::*;
;
  logic        clk, rstn, vld, a_vld, lcd_wr, k_vld, rbt;
  logic [7:0]  typ, a_typ, lcd_b, wide;
  logic [3:0]  len, a_len, slow, pwr_wr, pwm, hit, tach;
  logic [55:0] dat;
  logic [23:0] a_dat;
  logic [5:0]  keys, k_prs, k_rel;
  logic [2:0]  sel;
  logic [15:0] mode;
  logic [31:0] info, tpres, tcrc, pwr;
  int          errors = 0;
  int          n_checks = 0;

  hck_host hck_host_inst (.i_clk(clk), .o_valid(vld), .o_type(typ), .o_len(len), .o_data(dat));
  // short pwm step keeps the fail-safe wait near a thousand cycles
  hck_cmd_handler #(.STEP_CYCLES(4)) hck_cmd_handler_inst (
    .I_CORE_CLK(clk), .I_RSTN(rstn), .I_CMD_VALID(vld), .I_CMD_TYPE(typ),
    .I_CMD_LEN(len), .I_CMD_DATA(dat), .I_REBOOT(rbt), .I_KEYS(keys),
    .I_TEMP_PRESENT(tpres), .I_TEMP_CRC_ERR(tcrc), .I_FAN_SLOW(slow),
    .I_FAN_PWR(pwr), .I_FAN_PWR_WR(pwr_wr), .I_SLOT_SEL(sel),
    .O_ACK_VALID(a_vld), .O_ACK_TYPE(a_typ), .O_ACK_LEN(a_len), .O_ACK_DATA(a_dat),
    .O_LCD_WR(lcd_wr), .O_LCD_BYTE(lcd_b), .O_KEY_RPT_VALID(k_vld), .O_KEY_PRESS(k_prs),
    .O_KEY_RELEASE(k_rel), .O_SLOT_MODE(mode), .O_SLOT_WIDE(wide), .O_SLOT_INFO(info),
    .O_FAN_PWM(pwm), .O_TACH_EN(tach), .O_FAILSAFE_HIT(hit));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic cmd(input logic [7:0] t, input logic [3:0] l, input logic [55:0] d);
    logic [3:0] el;
    el = (t == CMD_KEY_POLL) ? LEN_POLL_ACK : LEN_EMPTY;
    hck_host_inst.send(t, l, d);
    #1 chk({a_vld, a_typ, a_len}, {1'b1, t | ACK_FLAG, el});
  endtask
  task automatic t_acks;
    cmd(CMD_LIVE_SLOT, LEN_SLOT_OFF, 56'h0005);
    cmd(CMD_LCD_RAW, 4'h1, 56'hA5);
    chk({lcd_wr, lcd_b}, 9'h1A5);
    cmd(CMD_GLITCH, LEN_GLITCH, 56'h01020304);
    cmd(CMD_KEY_POLL, LEN_EMPTY, 56'h0);
  endtask
  task automatic t_keys;
    @(posedge clk) keys <= 6'h01;
    @(posedge clk);
    #1 chk({k_vld, k_prs, k_rel}, 13'h1040);
    @(posedge clk) keys <= 6'h00;
    @(posedge clk);
    #1 chk({k_vld, k_prs, k_rel}, 13'h1001);
    cmd(CMD_KEY_MASK, LEN_KEY_MASK, 56'h0);
    @(posedge clk) keys <= 6'h03;
    @(posedge clk);
    #1 chk(k_vld, 1'b0);
    @(posedge clk) keys <= 6'h02;
    cmd(CMD_KEY_POLL, LEN_EMPTY, 56'h0);
    chk(a_dat, 24'h010302);
    // press lands in the poll cycle itself
    fork
      cmd(CMD_KEY_POLL, LEN_EMPTY, 56'h0);
      @(posedge clk) keys <= 6'h06;
    join
    chk(a_dat, 24'h000406);
  endtask
  task automatic t_slot;
    cmd(CMD_LIVE_SLOT, LEN_SLOT_ON, 56'h02010C04010102);
    // column 13 is one past the 4-digit limit, so slot 3 stays off
    cmd(CMD_LIVE_SLOT, LEN_SLOT_ON, 56'h02010D04010103);
    @(posedge clk) sel <= 3'h2;
    repeat (4) @(posedge clk);
    #1 chk(info, 32'h2B021);
    chk(mode, 16'h0010);
    @(posedge clk) slow <= 4'h2;
    repeat (8) @(posedge clk);
    #1 chk(mode, 16'h0030);
  endtask
  task automatic t_boot;
    hck_host_inst.send(CMD_STORE_BOOT, LEN_EMPTY, 56'h0);
    cmd(CMD_LIVE_SLOT, LEN_SLOT_OFF, 56'h0002);
    repeat (2) @(posedge clk);
    #1 chk(info, 32'h0);
    @(posedge clk) rbt <= 1'b1;
    @(posedge clk) rbt <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(info, 32'h2B021);
  endtask
  task automatic t_temp;
    // sensor 5 not attached yet, so this setup is refused
    cmd(CMD_LIVE_SLOT, LEN_SLOT_ON, 56'h01000B05050204);
    @(posedge clk) tpres <= 32'h20;
    #1 chk(mode, 16'h0030);
    cmd(CMD_LIVE_SLOT, LEN_SLOT_ON, 56'h01000B05050204);
    @(posedge clk);
    #1 chk({wide, mode}, 24'h100130);
    @(posedge clk) tcrc <= 32'h20;
    repeat (2) @(posedge clk);
    #1 chk(mode, 16'h0230);
  endtask
  task automatic t_fsafe;
    cmd(CMD_FAILSAFE, 4'h2, 56'h0101);
    chk(hit, 4'h0);
    repeat (1000) @(posedge clk);
    #1 chk({hit[0], pwm[0], tach[0]}, 3'h7);
    @(posedge clk) pwr_wr <= 4'h1;
    @(posedge clk) pwr_wr <= 4'h0;
    repeat (2) @(posedge clk);
    #1 chk(hit, 4'h0);
    @(posedge clk) pwr <= {PWR_FULL, 24'h0};
    repeat (2) @(posedge clk);
    #1 chk(pwm[3], 1'b1);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    errors++;
    results;
  end
  initial begin
    rstn = 1'b0;
    keys = 6'h00;
    slow = 4'h0;
    pwr_wr = 4'h0;
    sel = 3'h0;
    rbt = 1'b0;
    tpres = 32'h0;
    tcrc = 32'h0;
    pwr = 32'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_acks;
    t_keys;
    t_slot;
    t_boot;
    t_temp;
    t_fsafe;
    results;
  end
endmodule
